// ---- src/caf_cfg.svh ----
// register indices, field positions, reset values for the acceptance filter block
`ifndef CAF_CFG_SVH
`define CAF_CFG_SVH
// register index; byte address is index times four
`define CAF_IDX_CTRL 8'h0B
`define CAF_IDX_STAT 8'h0C
`define CAF_IDX_MISC 8'h0D
`define CAF_IDX_RECEIVE_FAULT_COUNT_BITS 8'h0E
`define CAF_IDX_TRANSMIT_FAULT_COUNT_BITS 8'h0F
`define CAF_IDX_CODE0 8'h10
`define CAF_IDX_MASK0 8'h18
// field positions
`define CAF_CTRL_LAYOUT_LSB 4
`define CAF_MISC_HOLD_BIT 0
`define CAF_STAT_HIT_LSB 0
`define CAF_STAT_REC_BIT 4
// reset values
`define CAF_RST_BYTE 8'h00
`define CAF_RST_COUNT 8'h00
`define CAF_RST_LAYOUT 2'h3
`define CAF_RST_HIT 3'h0
`endif

// ---- src/caf_pkg.sv ----
// types shared by the acceptance filter and fault counter block
package caf_pkg;
	typedef enum logic [1:0] {
		CAF_TWO_32 = 2'h0,
		CAF_FOUR_16 = 2'h1,
		CAF_EIGHT_8 = 2'h2,
		CAF_CLOSED = 2'h3
	} caf_layout_t;

	// identifier bytes of one received frame, byte 0 first
	typedef struct packed {
		logic [3:0][7:0] id;
		logic ext;
	} caf_frame_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} caf_wb_req_t;
endpackage

// ---- src/caf_top.sv ----
// acceptance filter, fault counter window and bus-off hold for a can controller
//
// What this block does
// - with recovery mode on, entering bus-off sets the hold flag and holds bus-off.
// - clearing the hold flag asks the core to start bus-off recovery.
// - hold flag readable always; writing one clears it, zero leaves it.
// - hold flag reads one only while bus-off and waiting for the user.
// - receive fault count readable at index 0x0E, resets to zero.
// - transmit fault count readable at index 0x0F, resets to zero.
// - counts read outside sleep or init mode may be stale.
// - every frame lands in the background buffer; only accepted ones are signalled.
// - a rejected frame is simply overwritten by the next one.
// - code registers are compared bit by bit with up to four identifier bytes: byte 0 only for 8-bit filters, bytes 0 and 1 for 16-bit ones.
// - extended identifiers use all four code and mask bytes of a 32-bit filter.
// - standard identifiers use only the first two code and mask byte pairs.
// - each code byte is compared with its identifier byte, then masked.
// - mask bit zero demands equality; mask bit one ignores the position.
// - a filter accepts only when every unmasked bit matches.
// - code and mask registers read anytime, written only in init mode.
// - layout field selects two 32-bit, four 16-bit, eight 8-bit filters or closed.
// - hit index names the accepting filter, updated on foreground load.
`timescale 1ns/10ps
`include "caf_cfg.svh"

module caf_top #(
	parameter int NUM_BYTES = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// mode handshakes from the control logic
	input wire logic init_request_i,
	input wire logic init_acknowledge_i,
	input wire logic sleep_request_i,
	input wire logic sleep_acknowledge_i,
	input wire logic busoff_recovery_mode_i,
	// error logic
	input wire logic busoff_enter_i,
	input wire logic [7:0] receive_fault_count_bits_i,
	input wire logic [7:0] transmit_fault_count_bits_i,
	output logic busoff_hold_flag_o,
	output logic recovery_request_o,
	// receiver
	input wire logic frame_valid_i,
	input wire caf_pkg::caf_frame_t frame_i,
	output logic frame_accept_o,
	output logic [2:0] filter_hit_index_o
);
	// byte wide match: mask one ignores, mask zero demands equality
	function automatic logic byte_match(input logic [7:0] id, input logic [7:0] code,
		input logic [7:0] mask);
		byte_match = &(~(id ^ code) | mask);
	endfunction

	// lowest set bit of the eight filter hits
	function automatic logic [2:0] lowest_hit(input logic [7:0] hits);
		lowest_hit = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (hits[i]) begin
				lowest_hit = 3'(i);
			end
		end
	endfunction

	// register index compare, shared by every single register decode
	function automatic logic idx_is(input logic [5:0] a, input logic [7:0] target);
		idx_is = a == target[5:0];
	endfunction

	caf_pkg::caf_wb_req_t req;
	logic ack_reg;
	logic [31:0] rdat_reg;
	logic [31:0] rdat_next;
	logic [7:0] code_reg [NUM_BYTES];
	logic [7:0] mask_reg [NUM_BYTES];
	caf_pkg::caf_layout_t layout_reg;
	logic hold_reg;
	logic rec_reg;
	logic [7:0] rxcnt_reg;
	logic [7:0] txcnt_reg;
	caf_pkg::caf_frame_t bg_reg;
	logic bg_new_reg;
	logic acc_reg;
	logic [2:0] hit_reg;
	logic hold_next;
	logic rec_next;
	logic acc_next;
	logic [2:0] hit_next;
	caf_pkg::caf_layout_t layout_next;

	assign req = '{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i};

	// bus decode
	wire access = req.cyc && req.stb && !ack_reg;
	wire [5:0] idx = req.adr[7:2];
	wire wr_lane0 = access && req.we && req.sel[0];
	wire init_mode = init_request_i && init_acknowledge_i;
	wire sleep_mode = sleep_request_i && sleep_acknowledge_i;
	wire hit_ctrl = idx_is(idx, `CAF_IDX_CTRL);
	wire hit_stat = idx_is(idx, `CAF_IDX_STAT);
	wire hit_misc = idx_is(idx, `CAF_IDX_MISC);
	wire hit_rx = idx_is(idx, `CAF_IDX_RECEIVE_FAULT_COUNT_BITS);
	wire hit_tx = idx_is(idx, `CAF_IDX_TRANSMIT_FAULT_COUNT_BITS);
	wire hit_code = idx[5:3] == 3'(`CAF_IDX_CODE0 >> 3);
	wire hit_mask = idx[5:3] == 3'(`CAF_IDX_MASK0 >> 3);
	wire [2:0] sub = idx[2:0];
	wire cfg_wr = wr_lane0 && init_mode;
	wire hold_clr = wr_lane0 && hit_misc && req.dat[`CAF_MISC_HOLD_BIT];
	wire hold_set = busoff_enter_i && busoff_recovery_mode_i;

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= access;
		end
	end

	// read selection; unmapped indices answer zero
	wire [31:0] rd_ctrl = 32'(layout_reg) << `CAF_CTRL_LAYOUT_LSB;
	wire [31:0] rd_hit = 32'(hit_reg) << `CAF_STAT_HIT_LSB;
	wire [31:0] rd_rec = 32'(rec_reg) << `CAF_STAT_REC_BIT;
	wire [31:0] rd_stat = rd_hit | rd_rec;
	wire [31:0] rd_misc = 32'(hold_reg) << `CAF_MISC_HOLD_BIT;
	wire [31:0] rd_rx = 32'(rxcnt_reg);
	wire [31:0] rd_tx = 32'(txcnt_reg);
	wire [31:0] rd_code = 32'(code_reg[sub]);
	wire [31:0] rd_mask = 32'(mask_reg[sub]);
	assign rdat_next = hit_ctrl ? rd_ctrl :
		hit_stat ? rd_stat :
		hit_misc ? rd_misc :
		hit_rx ? rd_rx :
		hit_tx ? rd_tx :
		hit_code ? rd_code :
		hit_mask ? rd_mask :
		32'h0000_0000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_reg <= 32'h0000_0000;
		end else if (access && !req.we) begin
			rdat_reg <= rdat_next;
		end
	end

	// configuration, written only while init is requested and granted
	generate
		for (genvar b = 0; b < NUM_BYTES; b++) begin : g_cfg
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					code_reg[b] <= `CAF_RST_BYTE;
					mask_reg[b] <= `CAF_RST_BYTE;
				end else if (cfg_wr && sub == 3'(b)) begin
					if (hit_code) begin
						code_reg[b] <= req.dat[7:0];
					end
					if (hit_mask) begin
						mask_reg[b] <= req.dat[7:0];
					end
				end
			end
		end
	endgenerate

	wire [1:0] layout_wdat = req.dat[`CAF_CTRL_LAYOUT_LSB +: 2];
	assign layout_next = (cfg_wr && hit_ctrl) ?
		caf_pkg::caf_layout_t'(layout_wdat) : layout_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			layout_reg <= caf_pkg::caf_layout_t'(`CAF_RST_LAYOUT);
		end else begin
			layout_reg <= layout_next;
		end
	end

	// bus-off hold; a new bus-off entry beats a clear in the same cycle,
	// so a fresh bus-off is never lost to a late software write
	assign hold_next = hold_set ? 1'b1 : (hold_clr ? 1'b0 : hold_reg);
	// no pulse when the flag was already clear: nothing to recover from
	assign rec_next = hold_reg && hold_clr && !hold_set;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_reg <= 1'b0;
			rec_reg <= 1'b0;
		end else begin
			hold_reg <= hold_next;
			rec_reg <= rec_next;
		end
	end

	assign busoff_hold_flag_o = hold_reg;
	assign recovery_request_o = rec_reg;

	// counts follow the error logic every cycle; a read outside sleep or
	// init may catch a value mid-update, which software must accept
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rxcnt_reg <= `CAF_RST_COUNT;
			txcnt_reg <= `CAF_RST_COUNT;
		end else begin
			rxcnt_reg <= receive_fault_count_bits_i;
			txcnt_reg <= transmit_fault_count_bits_i;
		end
	end

	// sleep_mode is only a hint here: no read is ever blocked
	wire counts_coherent = sleep_mode || init_mode;

	// background buffer takes every frame; next one overwrites a reject
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bg_reg <= '0;
			bg_new_reg <= 1'b0;
		end else begin
			bg_new_reg <= frame_valid_i;
			if (frame_valid_i) begin
				bg_reg <= frame_i;
			end
		end
	end

	// per filter hits for each layout
	logic [1:0] hit32;
	logic [3:0] hit16;
	logic [7:0] hit8;
	logic [7:0] hits;

	generate
		for (genvar f = 0; f < 2; f++) begin : g_f32
			wire m0 = byte_match(bg_reg.id[0], code_reg[4*f], mask_reg[4*f]);
			wire m1 = byte_match(bg_reg.id[1], code_reg[4*f+1], mask_reg[4*f+1]);
			wire m2 = byte_match(bg_reg.id[2], code_reg[4*f+2], mask_reg[4*f+2]);
			wire m3 = byte_match(bg_reg.id[3], code_reg[4*f+3], mask_reg[4*f+3]);
			assign hit32[f] = m0 && m1 && (!bg_reg.ext || (m2 && m3));
		end
		for (genvar f = 0; f < 4; f++) begin : g_f16
			wire m0 = byte_match(bg_reg.id[0], code_reg[2*f], mask_reg[2*f]);
			wire m1 = byte_match(bg_reg.id[1], code_reg[2*f+1], mask_reg[2*f+1]);
			assign hit16[f] = m0 && m1;
		end
		for (genvar f = 0; f < 8; f++) begin : g_f8
			assign hit8[f] = byte_match(bg_reg.id[0], code_reg[f], mask_reg[f]);
		end
	endgenerate

	always_comb begin
		unique case (layout_reg)
			caf_pkg::CAF_TWO_32: hits = {6'h00, hit32};
			caf_pkg::CAF_FOUR_16: hits = {4'h0, hit16};
			caf_pkg::CAF_EIGHT_8: hits = hit8;
			caf_pkg::CAF_CLOSED: hits = 8'h00;
		endcase
	end

	wire accept = bg_new_reg && (|hits);

	// foreground load: signal the processor and latch the hit index;
	// a rejected frame leaves the index of the last accepted one
	assign acc_next = accept;
	assign hit_next = accept ? lowest_hit(hits) : hit_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_reg <= 1'b0;
			hit_reg <= `CAF_RST_HIT;
		end else begin
			acc_reg <= acc_next;
			hit_reg <= hit_next;
		end
	end

	assign frame_accept_o = acc_reg;
	assign filter_hit_index_o = hit_reg;

	wire unused_ok = counts_coherent ^ (|req.sel[3:1]) ^ (|req.dat[31:8]);
endmodule

// ---- test/caf_top_asserts.sv ----
// port assertions for the filter and bus-off hold block
`timescale 1ns/10ps
module caf_top_asserts (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	input wire logic busoff_recovery_mode_i,
	input wire logic busoff_enter_i,
	input wire logic busoff_hold_flag_o,
	input wire logic recovery_request_o,
	input wire logic frame_valid_i,
	input wire logic frame_accept_o,
	input wire logic [2:0] filter_hit_index_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// misc register sits at index 0x0D, byte address 0x34
	wire clr = take && wb_we_i && wb_sel_i[0] && wb_dat_i[0] && wb_adr_i == 8'h34;
	wire hset = busoff_enter_i && busoff_recovery_mode_i;
	wire hold = busoff_hold_flag_o;
	ack_once_a: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a single cycle after request");
	hold_set_a: assert property (hset |=> hold)
		else $error("hold flag not set on bus-off");
	hold_keep_a: assert property (hold && !clr |=> hold)
		else $error("hold flag dropped without user clear");
	hold_clear_a: assert property (hold && clr && !hset |=> !hold && recovery_request_o)
		else $error("clear of hold flag gave no recovery");
	hold_idle_a: assert property (!hold && !hset |=> !hold)
		else $error("hold flag rose without bus-off");
	rec_cause_a: assert property (recovery_request_o |-> $past(hold) && !hold)
		else $error("recovery without a held flag");
	rec_pulse_a: assert property (recovery_request_o |=> !recovery_request_o)
		else $error("recovery pulse too long");
	acc_cause_a: assert property (frame_accept_o |-> $past(frame_valid_i, 2))
		else $error("accept without a frame two cycles back");
	hit_keep_a: assert property (!frame_accept_o && !$past(rst_i) |-> $stable(filter_hit_index_o))
		else $error("hit index moved without an accept");
	cover property (hold && clr);
	cover property (frame_accept_o && filter_hit_index_o == 3'h6);
	cover property (hset);
endmodule
bind caf_top caf_top_asserts u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_sel_i, .wb_dat_i, .wb_ack_o, .busoff_recovery_mode_i, .busoff_enter_i,
	.busoff_hold_flag_o, .recovery_request_o, .frame_valid_i, .frame_accept_o,
	.filter_hit_index_o);

// ---- test/caf_node.sv ----
// frame source standing in for the other nodes on the bus
`timescale 1ns/10ps
module caf_node (
	input wire logic clk_i,
	output logic frame_valid_o,
	output caf_pkg::caf_frame_t frame_o
);
	initial begin
		frame_valid_o = 1'b0;
		frame_o = '0;
	end
	// lines scramble between frames so a stale id never matches by luck
	task automatic send(input logic [31:0] id, input logic ext);
		frame_valid_o <= 1'b1;
		frame_o <= {id, ext};
		@(posedge clk_i);
		frame_valid_o <= 1'b0;
		frame_o <= ~frame_o;
	endtask
endmodule

// ---- test/caf_top_tb.sv ----
// self-checking bench for the filter and bus-off hold block
`timescale 1ns/10ps
`include "caf_cfg.svh"
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin error_cnt++; \
	$display("BAD %s exp %h got %h", nm, e, s); end end
module caf_top_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	caf_pkg::caf_wb_req_t q = '0;
	logic init_request_i = 1'b0;
	logic init_acknowledge_i = 1'b0;
	logic sleep_request_i = 1'b1;
	logic sleep_acknowledge_i = 1'b1;
	logic busoff_recovery_mode_i = 1'b0;
	logic busoff_enter_i = 1'b0;
	logic [7:0] receive_fault_count_bits_i = 8'h00;
	logic [7:0] transmit_fault_count_bits_i = 8'h00;
	logic [31:0] wb_dat_o, rdat;
	logic wb_ack_o, busoff_hold_flag_o, recovery_request_o, frame_valid_i, frame_accept_o;
	logic [2:0] filter_hit_index_o;
	caf_pkg::caf_frame_t frame_i;
	int error_cnt = 0, n_tests = 0, acc_n = 0, rec_n = 0;
	caf_top dut (.clk_i, .rst_i, .wb_cyc_i(q.cyc), .wb_stb_i(q.stb), .wb_we_i(q.we),
		.wb_adr_i(q.adr), .wb_sel_i(q.sel), .wb_dat_i(q.dat), .wb_dat_o, .wb_ack_o,
		.init_request_i, .init_acknowledge_i, .sleep_request_i, .sleep_acknowledge_i,
		.busoff_recovery_mode_i, .busoff_enter_i, .receive_fault_count_bits_i,
		.transmit_fault_count_bits_i, .busoff_hold_flag_o, .recovery_request_o,
		.frame_valid_i, .frame_i, .frame_accept_o, .filter_hit_index_o);
	caf_node n0 (.clk_i, .frame_valid_o(frame_valid_i), .frame_o(frame_i));
	initial forever #50 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		acc_n <= acc_n + int'(frame_accept_o === 1'b1);
		rec_n <= rec_n + int'(recovery_request_o === 1'b1);
	end
	task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int k;
		k = 0;
		q <= '{1'b1, 1'b1, w, {idx[5:0], 2'h0}, 4'hF, {24'h000000, d}};
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && k < 20) begin
			@(posedge clk_i);
			k++;
		end
		if (k >= 20) begin
			error_cnt++;
			complete_run();
		end
		rdat = wb_dat_o;
		q <= '0;
		@(posedge clk_i);
	endtask
	task automatic rchk(input logic [7:0] idx, input logic [7:0] e, input string nm);
		wb(1'b0, idx, 8'h00);
		`CHK(nm, {24'h000000, e}, rdat)
	endtask
	// accept shows two cycles after the frame; two spare edges let the count settle
	task automatic fr(input logic [31:0] id, input logic ext, input logic a, input logic [2:0] h);
		int c0;
		c0 = acc_n;
		n0.send(id, ext);
		repeat (4) @(posedge clk_i);
		`CHK("accept", int'(a), acc_n - c0)
		`CHK("hit", h, filter_hit_index_o)
	endtask
	task automatic t_regs();
		rchk(`CAF_IDX_RECEIVE_FAULT_COUNT_BITS, 8'h00, "rx reset");
		receive_fault_count_bits_i <= 8'h5C;
		transmit_fault_count_bits_i <= 8'hA3;
		rchk(`CAF_IDX_CTRL, 8'h30, "layout");
		rchk(`CAF_IDX_RECEIVE_FAULT_COUNT_BITS, 8'h5C, "rx count");
		rchk(`CAF_IDX_TRANSMIT_FAULT_COUNT_BITS, 8'hA3, "tx count");
		wb(1'b1, `CAF_IDX_RECEIVE_FAULT_COUNT_BITS, 8'hFF);
		rchk(`CAF_IDX_RECEIVE_FAULT_COUNT_BITS, 8'h5C, "rx read only");
		rchk(8'h3F, 8'h00, "unmapped");
		wb(1'b1, `CAF_IDX_CODE0, 8'h5A);
		rchk(`CAF_IDX_CODE0, 8'h00, "code locked");
	endtask
	task automatic t_filt();
		init_request_i <= 1'b1;
		init_acknowledge_i <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			wb(1'b1, 8'h10 + 8'(i), 8'(64'h44332211_D4C3B2A1 >> (8 * i)));
			wb(1'b1, 8'h18 + 8'(i), 8'(64'h07000700_07000700 >> (8 * i)));
		end
		wb(1'b1, `CAF_IDX_CTRL, 8'h00);
		rchk(`CAF_IDX_CODE0, 8'hA1, "code0");
		fr(32'hD4C3B2A1, 1'b1, 1'b1, 3'h0);
		fr(32'h44332211, 1'b1, 1'b1, 3'h1);
		fr(32'hD4C3B2A0, 1'b1, 1'b0, 3'h1);
		fr(32'h0000B5A1, 1'b0, 1'b1, 3'h0);
		wb(1'b1, `CAF_IDX_CTRL, 8'h10);
		fr(32'h00002211, 1'b0, 1'b1, 3'h2);
		wb(1'b1, `CAF_IDX_CTRL, 8'h20);
		n0.send(32'h000000EE, 1'b1);
		@(posedge clk_i);
		fr(32'h00000033, 1'b1, 1'b1, 3'h6);
		wb(1'b1, 8'h16, 8'hD4);
		fr(32'h000000D4, 1'b1, 1'b1, 3'h3);
		wb(1'b1, `CAF_IDX_CTRL, 8'h30);
		fr(32'hD4C3B2A1, 1'b1, 1'b0, 3'h3);
		rchk(`CAF_IDX_STAT, 8'h03, "hit status");
	endtask
	task automatic t_rst();
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk(`CAF_IDX_CTRL, 8'h30, "layout reset");
		rchk(`CAF_IDX_CODE0, 8'h00, "code reset");
		rchk(`CAF_IDX_STAT, 8'h00, "hit reset");
		`CHK("hold reset", 1'b0, busoff_hold_flag_o)
	endtask
	task automatic t_bus();
		int c;
		busoff_recovery_mode_i <= 1'b1;
		busoff_enter_i <= 1'b1;
		@(posedge clk_i);
		busoff_enter_i <= 1'b0;
		rchk(`CAF_IDX_MISC, 8'h01, "hold");
		`CHK("hold pin", 1'b1, busoff_hold_flag_o)
		wb(1'b1, `CAF_IDX_MISC, 8'h00);
		rchk(`CAF_IDX_MISC, 8'h01, "hold kept");
		c = rec_n;
		wb(1'b1, `CAF_IDX_MISC, 8'h01);
		rchk(`CAF_IDX_MISC, 8'h00, "hold cleared");
		`CHK("recovery", 1, rec_n - c)
		busoff_recovery_mode_i <= 1'b0;
		busoff_enter_i <= 1'b1;
		@(posedge clk_i);
		busoff_enter_i <= 1'b0;
		rchk(`CAF_IDX_MISC, 8'h00, "no hold");
	endtask
	task automatic complete_run();
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_filt();
		t_bus();
		t_rst();
		complete_run();
	end
	initial begin
		#2000000;
		error_cnt++;
		complete_run();
	end
endmodule
